//--- src/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_IRQ 8'h08
`define OFF_RESH 8'h0C
`define OFF_RESL 8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define C0_START 7
`define C0_BUSY 6
`define C0_PWR 5
`define C0_ALIGN 4
`define C1_SRC_HI 7
`define C1_SRC_LO 5
`define C1_REF_HI 4
`define C1_REF_LO 3
`define C1_DIV_HI 2
`define IRQ_GE 0
`define IRQ_CE 1
`define IRQ_FLAG 2
// ----------------------------------------
// Codes, counts and reset values
// ----------------------------------------
`define SEL_QUARTER 3'h4
`define SEL_GND_LO 3'h1
`define SEL_GND_HI 3'h3
`define VREF_SUPPLY 2'h1
`define VREF_AMP 2'h2
`define SAMPLE_LAST 4'h3
`define CONV_LAST 4'hD
`define DIV_FULL 7'h7F
`define DIV_TOP 3'h7
`define REG_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- src/adc_seq_pkg.sv
package adc_seq_pkg;
  typedef enum logic [1:0] {
    SRC_EXT = 2'b00, SRC_GND = 2'b01, SRC_QUARTER = 2'b10
  } src_route_t;
  typedef enum logic [1:0] {
    REF_PIN = 2'b00, REF_SUPPLY = 2'b01, REF_AMP = 2'b10
  } ref_route_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_HOLD = 2'b01, ST_SAMPLE = 2'b10, ST_CONVERT = 2'b11
  } seq_state_t;
  typedef struct packed {
    logic power;
    logic sampling;
    logic converting;
    src_route_t source;
    logic [3:0] channel;
    ref_route_t reference;
  } analog_ctrl_t;
endpackage

//--- src/adc_conversion_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"
// Contract
// R1: A start pulse is start bit low, high, then low again.
// R2: A started conversion sets busy and keeps it set while converting.
// R3: Busy clears when the conversion completes.
// R4: Completion sets the request flag; with both enables the interrupt is raised.
// R5: Divider code selects fsys divided by 1 up to 128 in powers of two.
// R6: Software keeps the conversion clock period between 0.5 and 10 us.
// R7: Software waits a settling delay after power enable before starting.
// R8: Conversion is 4 sampling plus 10 converting clocks, 14 in total.
// R9: Power enable low switches the converter circuitry off.
// R10: Software parks the channel field at 1000..1111 before internal source.
// R11: Software disables the reference pin when an internal reference is used.
// R12: Software sets result alignment before starting.
// R13: Software sets both interrupt enables before starting for interrupt use.
// R14: After busy falls the result is readable in high and low bytes.
// R15: Result is 10 bits, full scale 3FF.
// R16: Without interrupt, software polls busy until zero.
// R17: Alignment 0 gives high=D9..2, low=D1..0; 1 gives high=D9..8, low=D7..0.
// R18: Source 000,101..111 external; 100 quarter supply; 001..011 ground.
// R19: Reference 01 supply, 10 amplifier output, otherwise the reference pin.
// R20: Start high holds conversion reset; conversion begins on its fall.
// R21: With power enable low a start pulse is ignored.
module adc_conversion_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [9:0] conv_data,
  output adc_seq_pkg::analog_ctrl_t analog_ctrl,
  output logic conv_irq
);
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [7:0] waddr_q, wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  wire logic aw_take = s_axi_awvalid & awready_q;
  wire logic w_take = s_axi_wvalid & wready_q;
  wire logic b_done = bvalid_q & s_axi_bready;
  wire logic ar_take = s_axi_arvalid & arready_q;
  wire logic r_done = rvalid_q & s_axi_rready;
  wire logic do_wr = aw_have_q & w_have_q & ~bvalid_q;
  wire logic wr_hit = (waddr_q == `OFF_CTRL0) | (waddr_q == `OFF_CTRL1) |
    (waddr_q == `OFF_IRQ) | (waddr_q == `OFF_RESH) | (waddr_q == `OFF_RESL);
  wire logic wr_en = do_wr & wstrb_q;
  wire logic wr_c0 = wr_en & (waddr_q == `OFF_CTRL0);
  wire logic wr_c1 = wr_en & (waddr_q == `OFF_CTRL1);
  wire logic wr_irq = wr_en & (waddr_q == `OFF_IRQ);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      waddr_q <= `REG_RESET;
      wdata_q <= `REG_RESET;
      wstrb_q <= 1'b0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] c0_q, c1_q;
  logic ge_q, ce_q, flag_q, start_prev_q, conv_irq_q;
  logic [9:0] res_q;
  adc_seq_pkg::seq_state_t state_q, state_d;
  logic [3:0] cnt_q;
  logic [6:0] pre_q;
  wire logic start = c0_q[`C0_START];
  wire logic pwr = c0_q[`C0_PWR];
  wire logic align = c0_q[`C0_ALIGN];
  wire logic [2:0] src_sel = c1_q[`C1_SRC_HI:`C1_SRC_LO];
  wire logic [1:0] ref_sel = c1_q[`C1_REF_HI:`C1_REF_LO];
  wire logic [2:0] div_sel = c1_q[`C1_DIV_HI:0];
  wire logic busy = (state_q == adc_seq_pkg::ST_SAMPLE) |
    (state_q == adc_seq_pkg::ST_CONVERT);
  wire logic start_fall = start_prev_q & ~start; // [R1]
  wire logic [6:0] div_mask = `DIV_FULL >> (`DIV_TOP - div_sel); // [R5]
  wire logic tick = busy & (pre_q == div_mask);
  wire logic done = (state_q == adc_seq_pkg::ST_CONVERT) & tick &
    (cnt_q == `CONV_LAST) & pwr & ~start;
  wire logic [9:0] data_s;
  // Alignment applied on read, so a late change reformats the held result
  wire logic [7:0] res_hi = align ? {6'h00, res_q[9:8]} : res_q[9:2]; // [R17]
  wire logic [7:0] res_lo = align ? res_q[7:0] : {res_q[1:0], 6'h00}; // [R17]
  wire logic [7:0] c0_view = {start, busy, c0_q[5:0]}; // [R16]
  wire logic [7:0] irq_view = {5'h00, flag_q, ce_q, ge_q};
  wire logic rd_hit = (s_axi_araddr == `OFF_CTRL0) |
    (s_axi_araddr == `OFF_CTRL1) | (s_axi_araddr == `OFF_IRQ) |
    (s_axi_araddr == `OFF_RESH) | (s_axi_araddr == `OFF_RESL);
  wire logic [7:0] rd_byte =
    (s_axi_araddr == `OFF_CTRL0) ? c0_view :
    (s_axi_araddr == `OFF_CTRL1) ? c1_q :
    (s_axi_araddr == `OFF_IRQ) ? irq_view :
    (s_axi_araddr == `OFF_RESH) ? res_hi : // [R14]
    (s_axi_araddr == `OFF_RESL) ? res_lo : `REG_RESET;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0_q <= `REG_RESET;
      c1_q <= `REG_RESET;
      ge_q <= 1'b0;
      ce_q <= 1'b0;
      flag_q <= 1'b0;
      start_prev_q <= 1'b0;
      conv_irq_q <= 1'b0;
    end else begin
      if (wr_c0) c0_q <= wdata_q;
      if (wr_c1) c1_q <= wdata_q;
      if (wr_irq) begin
        ge_q <= wdata_q[`IRQ_GE];
        ce_q <= wdata_q[`IRQ_CE];
      end
      // Completion beats a clear in the same cycle
      flag_q <= done | (wr_irq ? wdata_q[`IRQ_FLAG] : flag_q); // [R4]
      start_prev_q <= start;
      conv_irq_q <= flag_q & ge_q & ce_q; // [R4]
    end
  end

  // ----------------------------------------
  // Result input synchroniser
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 10; i++) begin : g_sync
      logic s1_q, s2_q, s3_q, v_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          v_q <= 1'b0;
        end else begin
          s1_q <= conv_data[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) v_q <= s2_q;
        end
      end
      assign data_s[i] = v_q;
    end
  endgenerate

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adc_seq_pkg::ST_IDLE: begin
        if (start) state_d = adc_seq_pkg::ST_HOLD; // [R20]
      end
      adc_seq_pkg::ST_HOLD: begin
        if (start_fall) state_d = adc_seq_pkg::ST_SAMPLE; // [R1] [R2] [R20]
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (tick && cnt_q == `SAMPLE_LAST) state_d = adc_seq_pkg::ST_CONVERT; // [R8]
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (done) state_d = adc_seq_pkg::ST_IDLE; // [R3]
      end
    endcase
    if (start && state_q != adc_seq_pkg::ST_IDLE) state_d = adc_seq_pkg::ST_HOLD; // [R20]
    if (!pwr) state_d = adc_seq_pkg::ST_IDLE; // [R21]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= adc_seq_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      pre_q <= 7'h00;
      res_q <= 10'h000;
    end else begin
      state_q <= state_d;
      // Prescaler restarts with each conversion so the first clock is whole
      pre_q <= (!busy || tick) ? 7'h00 : pre_q + 7'h01; // [R5]
      cnt_q <= !busy ? 4'h0 : (tick ? cnt_q + 4'h1 : cnt_q); // [R8]
      if (done) res_q <= data_s; // [R14] [R15]
    end
  end

  // ----------------------------------------
  // Analog controls and outputs
  // ----------------------------------------
  adc_seq_pkg::analog_ctrl_t analog_q, analog_d;
  always_comb begin
    analog_d.power = pwr; // [R9]
    analog_d.sampling = pwr && state_d == adc_seq_pkg::ST_SAMPLE;
    analog_d.converting = pwr && state_d == adc_seq_pkg::ST_CONVERT;
    analog_d.channel = c0_q[3:0];
    if (src_sel == `SEL_QUARTER) analog_d.source = adc_seq_pkg::SRC_QUARTER; // [R18]
    else if (src_sel >= `SEL_GND_LO && src_sel <= `SEL_GND_HI)
      analog_d.source = adc_seq_pkg::SRC_GND; // [R18]
    else analog_d.source = adc_seq_pkg::SRC_EXT;
    if (ref_sel == `VREF_SUPPLY) analog_d.reference = adc_seq_pkg::REF_SUPPLY; // [R19]
    else if (ref_sel == `VREF_AMP) analog_d.reference = adc_seq_pkg::REF_AMP; // [R19]
    else analog_d.reference = adc_seq_pkg::REF_PIN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) analog_q <= '0;
    else analog_q <= analog_d;
  end

  assign analog_ctrl = analog_q;
  assign conv_irq = conv_irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Previous-cycle copies so a normal end is told apart from an abort
  logic busy_prev_q, pwr_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_prev_q <= 1'b0;
      pwr_prev_q <= 1'b0;
    end else begin
      busy_prev_q <= busy;
      pwr_prev_q <= pwr;
    end
  end
  wire logic end_ok = busy_prev_q & ~busy & pwr_prev_q & ~start_prev_q;

  busy_on_start_a: assert property ( // [R2]
    state_q == adc_seq_pkg::ST_HOLD && start_fall && pwr |=> busy && c0_view[`C0_BUSY])
    else $error("busy not set after start pulse");
  busy_end_a: assert property (end_ok |-> flag_q) // [R3]
    else $error("busy fell without completion flag");
  conv_len_a: assert property (end_ok |-> $past(cnt_q) == `CONV_LAST) // [R8]
    else $error("conversion not 14 clocks");
  result_cap_a: assert property (end_ok |-> res_q == $past(data_s)) // [R14]
    else $error("result not captured at completion");
  irq_out_a: assert property (flag_q && ge_q && ce_q |=> conv_irq) // [R4]
    else $error("interrupt not raised");
  div_tick_a: assert property (disable iff (!aresetn || !pwr || start) // [R5]
    state_q == adc_seq_pkg::ST_CONVERT && tick && cnt_q == 4'h4 && div_sel == 3'h4
    |=> !tick [*8] ##1 !tick [*7] ##1 tick)
    else $error("divide by sixteen spacing wrong");
  power_off_a: assert property (!pwr |=> !busy && !analog_ctrl.power) // [R9]
    else $error("converter active with power off");
  start_hold_a: assert property (start |=> !busy) // [R20]
    else $error("conversion runs while start high");
  align_read_a: assert property ( // [R17]
    ar_take && s_axi_araddr == `OFF_RESH && align && !done
    |=> rdata_q[7:0] == {6'h00, res_q[9:8]})
    else $error("right aligned high byte wrong");
  source_map_a: assert property ( // [R18]
    src_sel == `SEL_QUARTER |=> analog_ctrl.source == adc_seq_pkg::SRC_QUARTER)
    else $error("quarter supply not routed");
  ref_map_a: assert property ( // [R19]
    ref_sel == `VREF_AMP |=> analog_ctrl.reference == adc_seq_pkg::REF_AMP)
    else $error("amplifier reference not routed");
  full_conv_c: cover property (end_ok);
  abort_c: cover property (busy && !pwr);
  irq_c: cover property (conv_irq);
endmodule // adc_conversion_sequencer

//--- bench/adc_analog_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Converter side stand-in
// ----------------------------------------
module adc_analog_model (
  input wire logic aclk,
  input wire adc_seq_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [9:0] ext_code,
  output logic [9:0] conv_data
);
  logic [9:0] quarter_w;
  logic [9:0] code_w;
  assign quarter_w = (analog_ctrl.reference == adc_seq_pkg::REF_SUPPLY) ? 10'h100 :
    (analog_ctrl.reference == adc_seq_pkg::REF_AMP) ? 10'h155 : 10'h0C0;
  assign code_w = (analog_ctrl.source == adc_seq_pkg::SRC_GND) ? 10'h000 :
    (analog_ctrl.source == adc_seq_pkg::SRC_EXT) ? (ext_code ^ {6'h00, analog_ctrl.channel}) :
    quarter_w;
  initial conv_data = 10'h000;
  // Churns outside a conversion so a stale code never looks valid
  always @(posedge aclk) begin
    if (analog_ctrl.power && (analog_ctrl.sampling || analog_ctrl.converting)) begin
      conv_data <= code_w;
    end else begin
      conv_data <= ~conv_data;
    end
  end
endmodule // adc_analog_model

//--- bench/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module adc_conversion_sequencer_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0] conv_data, ext_code;
  adc_seq_pkg::analog_ctrl_t analog_ctrl;
  int err_total, compares, cyc, seed, samp_n, conv_n;

  adc_conversion_sequencer u_adc_conversion_sequencer (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_data, .analog_ctrl,
    .conv_irq);
  adc_analog_model u_adc_analog_model (.aclk, .analog_ctrl, .ext_code, .conv_data);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------
  // Phase counters and hang guard
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (analog_ctrl.sampling === 1'b1) samp_n++;
    if (analog_ctrl.converting === 1'b1) conv_n++;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [9:0] exp_code(input logic [2:0] s, input logic [1:0] f,
                                          input logic [3:0] c, input logic [9:0] e);
    if (s == 3'h4) return (f == 2'h1) ? 10'h100 : (f == 2'h2) ? 10'h155 : 10'h0C0;
    if (s == 3'h1 || s == 3'h2 || s == 3'h3) return 10'h000;
    return e ^ {6'h00, c};
  endfunction

  initial begin
    logic [2:0] src, dv;
    logic [1:0] rf;
    logic [3:0] ch;
    logic [9:0] ex, c;
    logic al, ie;
    logic [31:0] lh;
    int n;
    seed = 79561;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    ext_code = 10'h000;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // ----------------------------------------
    // Reset values and decode
    // ----------------------------------------
    for (int k = 0; k < 5; k++) begin
      rdr(8'(k * 4), rd, rsp);
      `CHK(rd, 32'h00000000, "reset value")
    end
    rdr(8'h14, rd, rsp);
    `CHK(rsp, `RESP_SLVERR, "unmapped read")
    wr(8'h14, 8'hFF, rsp);
    `CHK(rsp, `RESP_SLVERR, "unmapped write")
    $display("test regs done");
    // ----------------------------------------
    // Conversions over sources refs and dividers
    // ----------------------------------------
    for (int i = 0; i < 10; i++) begin
      src = (i % 3 == 0) ? 3'h4 : (i == 1) ? 3'h0 : (i == 2) ? 3'h1 : 3'($random(seed));
      rf = 2'(i);
      dv = (i == 0) ? 3'h4 : 3'h4 + 3'($random(seed) & 3);
      ch = 4'($random(seed));
      if (src == 3'h4) ch[3] = 1'b1;
      ex = 10'($random(seed));
      al = i[0];
      ie = i[1];
      wr(`OFF_CTRL0, {3'b001, al, ch}, rsp);
      wr(`OFF_CTRL1, {src, rf, dv}, rsp);
      wr(`OFF_IRQ, {6'h00, ie, ie}, rsp);
      ext_code <= ex;
      repeat (20) @(posedge aclk);
      wr(`OFF_CTRL0, {3'b101, al, ch}, rsp);
      rdr(`OFF_CTRL0, rd, rsp);
      `CHK(rd[7:6], 2'b10, "start held idle")
      `CHK(analog_ctrl.sampling, 1'b0, "no sampling in hold")
      samp_n = 0;
      conv_n = 0;
      wr(`OFF_CTRL0, {3'b001, al, ch}, rsp);
      rdr(`OFF_CTRL0, rd, rsp);
      `CHK(rd[6], 1'b1, "busy set")
      n = 0;
      while (rd[6] === 1'b1 && n < 2000) begin
        rdr(`OFF_CTRL0, rd, rsp);
        n++;
      end
      `CHK(rd[6], 1'b0, "busy clear")
      `CHK(samp_n, 4 << dv, "sample cycles")
      `CHK(conv_n, 10 << dv, "convert cycles")
      rdr(`OFF_IRQ, rd, rsp);
      `CHK(rd[2], 1'b1, "flag set")
      `CHK(conv_irq, ie, "irq level")
      c = exp_code(src, rf, ch, ex);
      rdr(`OFF_RESH, lh, rsp);
      `CHK(lh[7:0], al ? {6'h00, c[9:8]} : c[9:2], "result high")
      rdr(`OFF_RESL, rd, rsp);
      `CHK(rd[7:0], al ? c[7:0] : {c[1:0], 6'h00}, "result low")
      wr(`OFF_IRQ, 8'h00, rsp);
      repeat (2) @(posedge aclk);
      `CHK(conv_irq, 1'b0, "irq cleared")
      $display("test conversion %0d done", i);
    end
    // ----------------------------------------
    // Power off aborting a conversion, then start pulse with power off
    // ----------------------------------------
    wr(`OFF_CTRL0, 8'hA0, rsp);
    wr(`OFF_CTRL0, 8'h20, rsp);
    rdr(`OFF_CTRL0, rd, rsp);
    `CHK(rd[6], 1'b1, "busy before abort")
    wr(`OFF_CTRL0, 8'h80, rsp);
    wr(`OFF_CTRL0, 8'h00, rsp);
    repeat (40) @(posedge aclk);
    rdr(`OFF_CTRL0, rd, rsp);
    `CHK(rd[6], 1'b0, "no busy unpowered")
    `CHK(analog_ctrl.power, 1'b0, "converter off")
    rdr(`OFF_IRQ, rd, rsp);
    `CHK(rd[2], 1'b0, "no flag unpowered")
    rdr(`OFF_RESH, rd, rsp);
    // Alignment is back to 0 here
    `CHK(rd, {24'h000000, c[9:2]}, "result kept")
    $display("test power off done");
    conclude();
  end
endmodule // adc_conversion_sequencer_tb_top
